// >>> verilog/ipf_regs.vh
// register offsets, field positions and reset values of the interrupt block
`ifndef IPF_REGS_VH
`define IPF_REGS_VH

`define IPF_ADDR_W          24
`define IPF_OFF_BUS_CFG     24'h00ff00
`define IPF_OFF_STACK_PAGE  24'h00ff01
`define IPF_OFF_PRIO_A      24'h00ff20
`define IPF_OFF_PRIO_B      24'h00ff21
`define IPF_OFF_EN_A        24'h00ff22
`define IPF_OFF_EN_B        24'h00ff23
`define IPF_OFF_FLAG_A      24'h00ff24
`define IPF_OFF_FLAG_B      24'h00ff25
`define IPF_OFF_IRQ_STAT    24'h00ff26
`define IPF_OFF_IRQ_MASK    24'h00ff27

`define IPF_PRIO_A_RST      8'h00
`define IPF_PRIO_B_RST      8'h00
`define IPF_PRIO_B_MASK     8'h0f
`define IPF_EN_A_RST        8'h00
`define IPF_EN_A_MASK       8'h7f
`define IPF_EN_B_RST        8'h00
`define IPF_FLAG_RST        8'h00
`define IPF_FLAG_A_MASK     8'h7f

`define IPF_PRIO_KEY0_HI    7
`define IPF_PRIO_SER_HI     5
`define IPF_PRIO_SW_HI      3
`define IPF_PRIO_CT_HI      1
`define IPF_PRIO_PT_HI      3
`define IPF_PRIO_KEY1_HI    1

`define IPF_STAT_W          2
`define IPF_STAT_UNLOCK     0
`define IPF_STAT_PENDING    1

`endif

// >>> verilog/ipf_ctrl.v
// interrupt priority, enable and cause flag registers with request output
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ipf_regs.vh"

// Function
// - first input group priority, bits 7:6
// - serial priority in bits 5:4
// - stopwatch 3:2, clock timer 1:0
// - programmable timer priority 3:2, upper zero
// - second input port priority in 1:0
// - stopwatch enables in bits 6:4
// - clock timer enables 3:0, bit7 zero
// - timer one, zero, second port enables
// - first port upper and lower enables
// - serial error, receive, transmit enables
// - clock timer and stopwatch causes set flag register a
// - other causes set flag register b
// - write one clears flag, zero keeps
// - everything reads zero after reset
// - block interrupts until both config writes
module ipf_ctrl (
	input  wire                   CORE_CLK_I,
	input  wire                   RST_B_I,
	input  wire [`IPF_ADDR_W-1:0] ADDR_I,
	input  wire [7:0]             WDATA_I,
	input  wire                   WR_I,
	input  wire                   RD_I,
	input  wire [6:0]             CAUSE_A_I,
	input  wire [7:0]             CAUSE_B_I,
	output reg  [7:0]             RDATA_O,
	output reg  [14:0]            REQ_O,
	output reg  [1:0]             REQ_LEVEL_O,
	output reg                    REQ_VALID_O,
	output reg                    IRQ_O
);

	// overview of the block:
	// - six byte registers sit on the internal i/o bus
	// - two hold two-bit priority levels per source group
	// - two hold one enable bit per interrupt cause
	// - two hold one sticky cause flag per interrupt cause
	// - a cause flag is set by a rising edge on its cause line
	// - a cause flag is cleared by writing a one to its bit
	// - writing a zero to a flag bit leaves that flag alone
	// - a cause is pending while its flag and enable are both one
	// - the request vector shows every pending cause at once
	// - the level output shows the highest level among them
	// - nothing is requested before the two setup writes land
	// - the setup writes only need to happen, data is ignored
	// - an extra status and mask pair drives one level interrupt
	// group order in the request vector, low bit first:
	// - bits 3:0 clock timer 1, 2, 8 and 32 hz
	// - bits 6:4 stopwatch 1, 10 and 100 hz
	// - bits 9:7 serial transmit, receive and error
	// - bits 11:10 first input port lower and upper lines
	// - bit 12 second input port lines
	// - bits 14:13 programmable timers zero and one
	// limitations a user must know:
	// - cause lines must already be on this clock, no synchroniser
	// - a cause held high sets its flag only once, on its edge
	// - a clear and a new edge in one cycle leave the flag set
	// - the level output is one cycle behind the flags
	// - reserved bits are dropped on write and read as zero
	// - unmapped addresses read zero and ignore writes
	// - every output comes straight from a flip-flop

	// register file
	reg [7:0] prio_a;
	reg [7:0] prio_b;
	reg [7:0] en_a;
	reg [7:0] en_b;
	reg [7:0] flag_a;
	reg [7:0] flag_b;
	reg       cfg_seen;
	reg       page_seen;
	reg       cfg_seen_d;
	reg [`IPF_STAT_W-1:0] irq_stat;
	reg [`IPF_STAT_W-1:0] irq_mask;

	// cause pulses are level strobes from peripherals on this clock
	reg [7:0] cause_a_prev;
	reg [7:0] cause_b_prev;

	// write decode, one strobe per register
	// the full 24-bit address is compared so that mirrors of
	// these registers elsewhere in the map cannot exist
	// the strobe lasts one cycle, so each write acts once
	// reads need no decode strobe, the read mux below
	// looks at the address directly
	// the two setup addresses are decoded here as well,
	// although only their write event is kept
	wire       wr_prio_a = WR_I && (ADDR_I == `IPF_OFF_PRIO_A);
	wire       wr_prio_b = WR_I && (ADDR_I == `IPF_OFF_PRIO_B);
	wire       wr_en_a   = WR_I && (ADDR_I == `IPF_OFF_EN_A);
	wire       wr_en_b   = WR_I && (ADDR_I == `IPF_OFF_EN_B);
	wire       wr_flag_a = WR_I && (ADDR_I == `IPF_OFF_FLAG_A);
	wire       wr_flag_b = WR_I && (ADDR_I == `IPF_OFF_FLAG_B);
	wire       wr_stat   = WR_I && (ADDR_I == `IPF_OFF_IRQ_STAT);
	wire       wr_mask   = WR_I && (ADDR_I == `IPF_OFF_IRQ_MASK);
	wire       wr_cfg    = WR_I && (ADDR_I == `IPF_OFF_BUS_CFG);
	wire       wr_page   = WR_I && (ADDR_I == `IPF_OFF_STACK_PAGE);

	// rising edge of each cause sets its flag once per event
	wire [7:0] set_a = {1'b0, CAUSE_A_I} & ~cause_a_prev;
	wire [7:0] set_b = CAUSE_B_I & ~cause_b_prev;

	// flag update: set wins over a simultaneous clear
	// losing an event is worse than a spurious interrupt,
	// since software can always read the flag and find it set
	// the clear mask is zero unless the flag register is written
	// bit 7 of the first flag register does not exist and is
	// forced to zero here so it can never read as one
	wire [7:0] clr_a = wr_flag_a ? WDATA_I : 8'h00;
	wire [7:0] clr_b = wr_flag_b ? WDATA_I : 8'h00;
	wire [7:0] next_flag_a = ((flag_a & ~clr_a) | set_a)
		& `IPF_FLAG_A_MASK;
	wire [7:0] next_flag_b = (flag_b & ~clr_b) | set_b;

	// pending causes: flag and enable both one
	wire [14:0] pend = {flag_b & en_b, flag_a[6:0] & en_a[6:0]};
	wire        unlock = cfg_seen & page_seen;

	// level of each group, all four fields of register a and two of b
	wire [1:0] lv_key0 = prio_a[`IPF_PRIO_KEY0_HI -: 2];
	wire [1:0] lv_ser  = prio_a[`IPF_PRIO_SER_HI -: 2];
	wire [1:0] lv_sw   = prio_a[`IPF_PRIO_SW_HI -: 2];
	wire [1:0] lv_ct   = prio_a[`IPF_PRIO_CT_HI -: 2];
	wire [1:0] lv_pt   = prio_b[`IPF_PRIO_PT_HI -: 2];
	wire [1:0] lv_key1 = prio_b[`IPF_PRIO_KEY1_HI -: 2];

	// highest level among pending groups; ties keep the earlier group
	reg [1:0] next_level;
	reg       next_any;
	always @* begin
		next_level = 2'b00;
		next_any   = 1'b0;
		if (|pend[3:0]) begin
			next_any = 1'b1;
			next_level = lv_ct;
		end
		if (|pend[6:4] && (!next_any || lv_sw > next_level)) begin
			next_any = 1'b1;
			next_level = lv_sw;
		end
		if (|pend[9:7] && (!next_any || lv_ser > next_level)) begin
			next_any = 1'b1;
			next_level = lv_ser;
		end
		if (|pend[11:10] && (!next_any || lv_key0 > next_level)) begin
			next_any = 1'b1;
			next_level = lv_key0;
		end
		if (pend[12] && (!next_any || lv_key1 > next_level)) begin
			next_any = 1'b1;
			next_level = lv_key1;
		end
		if (|pend[14:13] && (!next_any || lv_pt > next_level)) begin
			next_any = 1'b1;
			next_level = lv_pt;
		end
	end

	// read mux; unmapped addresses read zero
	// the mux is combinational and its result is captured
	// only in the cycle of the read strobe, so the data
	// stand for exactly one cycle after the strobe
	// masks on read repeat the masks on write so that
	// a reserved bit cannot appear even after a glitch
	// the extra status and mask registers sit right above
	// the six flag and control registers
	reg [7:0] next_rdata;
	always @* begin
		case (ADDR_I)
			`IPF_OFF_PRIO_A:   next_rdata = prio_a;
			`IPF_OFF_PRIO_B:   next_rdata = prio_b & `IPF_PRIO_B_MASK;
			`IPF_OFF_EN_A:     next_rdata = en_a & `IPF_EN_A_MASK;
			`IPF_OFF_EN_B:     next_rdata = en_b;
			`IPF_OFF_FLAG_A:   next_rdata = flag_a;
			`IPF_OFF_FLAG_B:   next_rdata = flag_b;
			`IPF_OFF_IRQ_STAT: next_rdata = {6'h00, irq_stat};
			`IPF_OFF_IRQ_MASK: next_rdata = {6'h00, irq_mask};
			default:           next_rdata = 8'h00;
		endcase
	end

	// summary events: unlock reached, any gated request present
	// the unlock event is a one-cycle pulse on the first cycle
	// in which both setup writes have been seen
	// the pending event stays high while any request is open,
	// so clearing its status bit only works once the flags
	// behind it have been cleared
	// both status bits follow the same set-wins rule as flags
	wire [`IPF_STAT_W-1:0] ev;
	assign ev[`IPF_STAT_UNLOCK]  = unlock & ~(cfg_seen_d);
	assign ev[`IPF_STAT_PENDING] = unlock & next_any;
	wire [`IPF_STAT_W-1:0] stat_clr = wr_stat ?
		WDATA_I[`IPF_STAT_W-1:0] : {`IPF_STAT_W{1'b0}};
	wire [`IPF_STAT_W-1:0] next_stat = (irq_stat & ~stat_clr) | ev;

	// first priority register, four level fields
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			prio_a <= `IPF_PRIO_A_RST;
		end else begin
			if (wr_prio_a) begin
				prio_a <= WDATA_I;
			end
		end
	end

	// second priority register, upper nibble never stored
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			prio_b <= `IPF_PRIO_B_RST;
		end else begin
			if (wr_prio_b) begin
				prio_b <= WDATA_I & `IPF_PRIO_B_MASK;
			end
		end
	end

	// timer enables, bit 7 never stored
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			en_a <= `IPF_EN_A_RST;
		end else begin
			if (wr_en_a) begin
				en_a <= WDATA_I & `IPF_EN_A_MASK;
			end
		end
	end

	// port, timer and serial enables, all eight bits used
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			en_b <= `IPF_EN_B_RST;
		end else begin
			if (wr_en_b) begin
				en_b <= WDATA_I;
			end
		end
	end

	// timer cause flags
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			flag_a <= `IPF_FLAG_RST;
		end else begin
			flag_a <= next_flag_a;
		end
	end

	// port, timer and serial cause flags
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			flag_b <= `IPF_FLAG_RST;
		end else begin
			flag_b <= next_flag_b;
		end
	end

	// bus setup write seen; the value written does not matter
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cfg_seen <= 1'b0;
		end else begin
			if (wr_cfg) begin
				cfg_seen <= 1'b1;
			end
		end
	end

	// stack page write seen; either order unlocks
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			page_seen <= 1'b0;
		end else begin
			if (wr_page) begin
				page_seen <= 1'b1;
			end
		end
	end

	// delayed unlock for the one-shot unlock event
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cfg_seen_d <= 1'b0;
		end else begin
			cfg_seen_d <= unlock;
		end
	end

	// last cause levels, low after reset like idle lines
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cause_a_prev <= 8'h00;
		end else begin
			cause_a_prev <= {1'b0, CAUSE_A_I};
		end
	end

	// last cause levels of the second group
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cause_b_prev <= 8'h00;
		end else begin
			cause_b_prev <= CAUSE_B_I;
		end
	end

	// summary status, sticky, cleared by writing ones
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			irq_stat <= {`IPF_STAT_W{1'b0}};
		end else begin
			irq_stat <= next_stat;
		end
	end

	// summary mask, same layout as the status
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			irq_mask <= {`IPF_STAT_W{1'b0}};
		end else begin
			if (wr_mask) begin
				irq_mask <= WDATA_I[`IPF_STAT_W-1:0];
			end
		end
	end

	// read data for one cycle only, zero otherwise
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			RDATA_O <= 8'h00;
		end else begin
			RDATA_O <= RD_I ? next_rdata : 8'h00;
		end
	end

	// gated by the lock so nothing leaks out before setup
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			REQ_O <= 15'h0000;
		end else begin
			REQ_O <= unlock ? pend : 15'h0000;
		end
	end

	// level of the highest pending group
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			REQ_LEVEL_O <= 2'b00;
		end else begin
			REQ_LEVEL_O <= unlock ? next_level : 2'b00;
		end
	end

	// any request open
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			REQ_VALID_O <= 1'b0;
		end else begin
			REQ_VALID_O <= unlock & next_any;
		end
	end

	// level interrupt from the next status, saves a cycle
	always @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			IRQ_O <= 1'b0;
		end else begin
			IRQ_O <= |(next_stat & irq_mask);
		end
	end

endmodule // ipf_ctrl
`default_nettype wire

// >>> test/ipf_src_model.sv
// cause pulse source for the timers, ports and serial unit
`timescale 1ns/1ps
`default_nettype none
module ipf_src_model (
	input  wire logic        clk_i,
	input  wire logic [14:0] fire_i,
	output var  logic [6:0]  cause_a_o = 7'h00,
	output var  logic [7:0]  cause_b_o = 8'h00
);
	// registered copy of fire, so a one-cycle fire is a fresh rising edge
	always @(posedge clk_i)
		{cause_b_o, cause_a_o} <= fire_i;
endmodule // ipf_src_model
`default_nettype wire

// >>> test/ipf_ctrl_monitor.sv
// assertion checker for the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module ipf_ctrl_monitor (
	input wire logic        CORE_CLK_I,
	input wire logic        RST_B_I,
	input wire logic [23:0] ADDR_I,
	input wire logic [7:0]  WDATA_I,
	input wire logic        WR_I,
	input wire logic        RD_I,
	input wire logic [6:0]  CAUSE_A_I,
	input wire logic [7:0]  CAUSE_B_I,
	input wire logic [7:0]  RDATA_O,
	input wire logic [14:0] REQ_O,
	input wire logic [1:0]  REQ_LEVEL_O,
	input wire logic        REQ_VALID_O,
	input wire logic        IRQ_O
);
	logic b;
	logic s;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_B_I);
	// unlock writes seen on the bus
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
		if (!RST_B_I)
			{b, s} <= 2'b00;
		else if (WR_I)
			{b, s} <= {b | ADDR_I == 24'h00ff00, s | ADDR_I == 24'h00ff01};
	property p_lock; !(b && s) |-> REQ_O == 15'h0000; endproperty
	property p_vld; REQ_VALID_O == (REQ_O != 15'h0000); endproperty
	property p_lvl; !REQ_VALID_O |-> REQ_LEVEL_O == 2'h0; endproperty
	property p_rdb; RD_I && ADDR_I == 24'h00ff21 |=> RDATA_O[7:4] == 4'h0;
	endproperty
	property p_rd7; RD_I && (ADDR_I == 24'h00ff22 || ADDR_I == 24'h00ff24)
		|=> !RDATA_O[7];
	endproperty
	property p_idle; !RD_I |=> RDATA_O == 8'h00; endproperty
	property p_clr; WR_I && ADDR_I == 24'h00ff24 && WDATA_I[0]
		&& !$rose(CAUSE_A_I[0]) |-> ##2 !REQ_O[0]; endproperty
	property p_rst; $rose(RST_B_I) |-> REQ_O == 15'h0000 && !IRQ_O;
	endproperty
	a_lock: assert property (p_lock) else $error("request while locked");
	a_vld: assert property (p_vld) else $error("valid mismatch");
	a_lvl: assert property (p_lvl) else $error("level without request");
	a_rdb: assert property (p_rdb) else $error("upper bits set");
	a_rd7: assert property (p_rd7) else $error("bit 7 set");
	a_idle: assert property (p_idle) else $error("read data held");
	a_clr: assert property (p_clr) else $error("flag not cleared");
	a_rst: assert property (p_rst) else $error("output after reset");
	c_vld: cover property (REQ_VALID_O);
	c_irq: cover property (IRQ_O);
	c_top: cover property (REQ_LEVEL_O == 2'h3);
endmodule // ipf_ctrl_monitor
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [23:0] addr = 24'h000000;
	logic [7:0]  wd = 8'h00;
	logic [14:0] fire = 15'h0000;
	logic [6:0]  ca;
	logic [7:0]  cb;
	logic [7:0]  rdata;
	logic [14:0] req;
	logic [1:0]  lvl;
	logic        vld;
	logic        irq;
	logic [7:0]  v [4];
	logic [7:0]  w;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          seed = 51;
	always #12.5 clk = ~clk;
	ipf_src_model src (.clk_i(clk), .fire_i(fire), .cause_a_o(ca),
		.cause_b_o(cb));
	ipf_ctrl dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr),
		.WDATA_I(wd), .WR_I(wr), .RD_I(rd), .CAUSE_A_I(ca), .CAUSE_B_I(cb),
		.RDATA_O(rdata), .REQ_O(req), .REQ_LEVEL_O(lvl), .REQ_VALID_O(vld),
		.IRQ_O(irq));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		{wr, addr, wd} <= {1'b1, 16'h00ff, a, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		{rd, addr} <= {1'b1, 16'h00ff, a};
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// highest level among all six groups
	function automatic logic [1:0] top(input logic [7:0] a, input logic [7:0] b);
		logic [1:0] m;
		m = b[3:2] > b[1:0] ? b[3:2] : b[1:0];
		for (int i = 0; i < 8; i += 2)
			m = a[i+:2] > m ? a[i+:2] : m;
		return m;
	endfunction
	task finish_test;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// watchdog, tests need about 150 cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 32; i < 39; i++)
			rd_reg(i[7:0], 8'h00);
		$display("reset test done");
		for (int k = 0; k < 6; k++) begin
			for (int j = 0; j < 4; j++) begin
				v[j] = $random(seed);
				wr_reg(8'h20 + j[7:0], v[j]);
			end
			for (int j = 0; j < 4; j++)
				rd_reg(8'h20 + j[7:0], v[j] & (j == 1 ? 8'h0f : j == 2 ? 8'h7f : 8'hff));
		end
		$display("field test done");
		wr_reg(8'h22, 8'h7f);
		wr_reg(8'h23, 8'hff);
		fire <= 15'h7fff;
		@(posedge clk);
		fire <= 15'h0000;
		repeat (3) @(posedge clk);
		#1 chk(req, 15'h0000);
		rd_reg(8'h24, 8'h7f);
		rd_reg(8'h25, 8'hff);
		wr_reg(8'h00, 8'h5a);
		wr_reg(8'h01, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk(req, 15'h7fff);
		chk(lvl, top(v[0], v[1] & 8'h0f));
		$display("lock test done");
		w = $random(seed) & 8'h3f;
		wr_reg(8'h24, w);
		rd_reg(8'h24, 8'h7f & ~w);
		wr_reg(8'h27, 8'h02);
		repeat (2) @(posedge clk);
		#1 chk(irq, 1'b1);
		wr_reg(8'h24, 8'hff);
		wr_reg(8'h25, 8'hff);
		repeat (3) @(posedge clk);
		wr_reg(8'h26, 8'hff);
		repeat (3) @(posedge clk);
		#1 chk({vld, irq}, 2'b00);
		$display("clear test done");
		finish_test;
	end
endmodule // tb_top
bind ipf_ctrl ipf_ctrl_monitor mon (.CORE_CLK_I(CORE_CLK_I),
	.RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
	.RD_I(RD_I), .CAUSE_A_I(CAUSE_A_I), .CAUSE_B_I(CAUSE_B_I),
	.RDATA_O(RDATA_O), .REQ_O(REQ_O), .REQ_LEVEL_O(REQ_LEVEL_O),
	.REQ_VALID_O(REQ_VALID_O), .IRQ_O(IRQ_O));
`default_nettype wire
